// >>> dv/sam_monitor_model.sv
/*
  monitor side model: drives the half input and sync input pins and measures
  the generated hsync. assumes pclk clocking and active low presetn.
*/
module sam_monitor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rnd,
  input wire logic horizontal_sync_output,
  input wire logic horizontal_sync_oe_n,
  output logic half_input_pin,
  output logic hsync_in,
  output logic vsync_in,
  output int h_period,
  output int h_width
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  int cnt;
  int hi;
  logic hs_q;
  logic hs;
  // a released sync pin is not looked at
  assign hs = !horizontal_sync_oe_n && horizontal_sync_output;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 0;
      half_input_pin <= 1'b0;
      hsync_in <= 1'b0;
      vsync_in <= 1'b0;
      hs_q <= 1'b0;
      cnt <= 0;
      hi <= 0;
      h_period <= 0;
      h_width <= 0;
    end else begin
      ph <= (ph + 1) % 8;
      if (rnd) begin
        {half_input_pin, hsync_in, vsync_in} <= 3'($urandom);
      end else begin
        half_input_pin <= (ph < 4);
        hsync_in <= 1'b0;
        vsync_in <= 1'b0;
      end
      hs_q <= hs;
      if (hs && !hs_q) begin
        h_period <= cnt;
        cnt <= 1;
        hi <= 1;
      end else begin
        cnt <= cnt + 1;
        if (hs) begin
          hi <= hi + 1;
        end
      end
      if (!hs && hs_q) begin
        h_width <= hi;
      end
    end
  end
endmodule

// >>> dv/test_sync_aux_output_and_mode_detect.sv
/*
  self checking bench of sam_top: apb register access, half path, free-run
  and mute detection. assumes a 50 mhz pclk and zero wait state apb.
*/
module test_sync_aux_output_and_mode_detect import sam_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rnd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hin, hs_in, vs_in, hout, hout_oe_n, hso, hso_oe_n, vso, vso_oe_n, pat, pat_oe_n, nmi;
  logic ph, ps;
  sam_sync_stat_s ss;
  int h_period, h_width, n_mismatch, num_checks, tr, hi;
  logic [32:0] expq [$];
  logic [32:0] exp_v;
  logic [11:0] ra [7] = '{12'h01c, 12'h030, 12'h034, 12'h038, 12'h058, 12'h060, 12'h03c};
  logic [7:0] rv [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  int hd [6] = '{256, 180, 128, 100, 88, 88};
  sam_top #(.HCW(11), .VCW(11)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .half_input_pin(hin), .hsync_in(hs_in),
    .vsync_in(vs_in), .sync_stat(ss), .half_output_pin(hout), .half_output_oe_n(hout_oe_n),
    .horizontal_sync_output(hso), .horizontal_sync_oe_n(hso_oe_n),
    .vertical_sync_output(vso), .vertical_sync_oe_n(vso_oe_n), .pattern_output_pin(pat),
    .pattern_oe_n(pat_oe_n), .nmi_req(nmi));
  sam_monitor_model PM (.pclk(pclk), .presetn(presetn), .rnd(rnd), .horizontal_sync_output(hso),
    .horizontal_sync_oe_n(hso_oe_n), .half_input_pin(hin), .hsync_in(hs_in), .vsync_in(vs_in),
    .h_period(h_period), .h_width(h_width));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task end_sim;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task chk_num(input string nm, input int e, input int g);
    num_checks++;
    if (g != e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task chk_reg(input logic [11:0] a, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED read %h expected %h seen %h", a, e, g);
    end
  endtask
  task xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic err);
    expq.push_back({err, 24'h0, e});
    xfer(a, 1'b0, 8'h00);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task stat_pulse(input logic [11:0] hc, input logic ov);
    @(posedge pclk);
    ss.hcount <= hc;
    ss.hcount_latch <= !ov;
    ss.hcnt_ov <= ov;
    @(posedge pclk);
    ss.hcount_latch <= 1'b0;
    ss.hcnt_ov <= 1'b0;
  endtask
  // read monitor: compares the oldest note at each read access edge
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 33'bx;
      chk_reg(paddr, exp_v, {pslverr, prdata});
    end
  end
  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    void'($urandom(79279));
    {ce, psel, penable, pwrite, paddr, pwdata, rnd, presetn} = '0;
    ce = 1'b1;
    ss = '0;
    ss.hpol = 1'b1;
    ss.vpol = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk_bit("half_oe_n", 1'b1, hout_oe_n);
    chk_bit("sync_oe_n", 1'b1, hso_oe_n & vso_oe_n);
    chk_bit("nmi_req", 1'b0, nmi);
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i], i == 6);
    @(posedge pclk);
    ce <= 1'b0;
    wr(12'h060, 8'h01);
    ce <= 1'b1;
    rd(12'h060, 8'h00, 1'b0);
    stat_pulse(12'h123, 1'b1);
    rd(12'h058, 8'h00, 1'b0);
    wr(12'h060, 8'h01);
    wr(12'h038, 8'hdf);
    stat_pulse(12'h000, 1'b1);
    wait_n(1);
    chk_bit("nmi_req", 1'b1, nmi);
    rd(12'h058, 8'h01, 1'b0);
    rd(12'h058, 8'h01, 1'b0);
    wr(12'h058, 8'h01);
    wait_n(0);
    chk_bit("nmi_req", 1'b0, nmi);
    wr(12'h060, 8'h00);
    stat_pulse(12'h000, 1'b1);
    wait_n(1);
    chk_bit("nmi_req", 1'b0, nmi);
    wr(12'h038, 8'hbf);
    wr(12'h058, 8'h01);
    @(posedge pclk);
    ss.vpol <= 1'b0;
    rd(12'h058, 8'h01, 1'b0);
    wr(12'h038, 8'h73);
    wr(12'h058, 8'h01);
    stat_pulse(12'd100, 1'b0);
    rd(12'h058, 8'h01, 1'b0);
    wr(12'h058, 8'h01);
    stat_pulse(12'd103, 1'b0);
    rd(12'h058, 8'h00, 1'b0);
    stat_pulse(12'd99, 1'b0);
    rd(12'h058, 8'h01, 1'b0);
    wr(12'h058, 8'h01);
    wr(12'h034, 8'h7f);
    wait_n(8);
    chk_bit("half_oe_n", 1'b0, hout_oe_n);
    tr = 0;
    hi = 0;
    ph = hout;
    repeat (128) begin
      @(negedge pclk);
      tr += (hout !== ph);
      hi += (hout === 1'b1);
      ph = hout;
    end
    chk_num("half_toggles", 16, tr);
    chk_num("half_high", 64, hi);
    @(posedge pclk);
    rnd <= 1'b1;
    wr(12'h030, 8'h00);
    for (int p = 1; p >= 0; p--) begin
      wr(12'h034, p ? 8'hbf : 8'h9f);
      wait_n(2);
      ph = hin;
      ps = hs_in;
      repeat (24) begin
        @(negedge pclk);
        chk_bit("half_out", p ? ph : ~ph, hout);
        chk_bit("hsync_out", ps, hso);
        ph = hin;
        ps = hs_in;
      end
    end
    rd(12'h058, 8'h00, 1'b0);
    @(posedge pclk);
    rnd <= 1'b0;
    wr(12'h01c, 8'h7f);
    wait_n(1);
    chk_bit("hsync_oe_n", 1'b0, hso_oe_n);
    chk_bit("vsync_oe_n", 1'b1, vso_oe_n);
    rd(12'h058, 8'h02, 1'b0);
    for (int c = 0; c < 6; c++) begin
      wr(12'h030, 8'h80 | 8'(c));
      wait_n(hd[c] * 25 / 4 * 3);
      chk_num("h_period", hd[c] * 25 / 4, h_period);
      chk_num("h_width", 50, h_width);
    end
    wr(12'h01c, 8'hff);
    wr(12'h030, 8'h05);
    wr(12'h01c, 8'h7f);
    wait_n(2);
    chk_bit("pattern_oe_n", 1'b1, pat_oe_n);
    wr(12'h030, 8'h05);
    wait_n(2);
    chk_bit("pattern_oe_n", 1'b0, pat_oe_n);
    chk_bit("pattern_pin", 1'b0, pat);
    chk_bit("vsync_out", 1'b1, vso);
    wr(12'h030, 8'h45);
    wait_n(2);
    chk_bit("pattern_oe_n", 1'b0, pat_oe_n);
    wr(12'h030, 8'h06);
    wait_n(2);
    chk_bit("pattern_oe_n", 1'b1, pat_oe_n);
    rd(12'h058, 8'h00, 1'b0);
    wr(12'h01c, 8'h3f);
    wait_n(1);
    chk_bit("vsync_oe_n", 1'b0, vso_oe_n);
    wait_n(2);
    end_sim;
  end
endmodule

// >>> rtl/sam_pkg.sv
/*
  types of the sync auxiliary block. assumes the sync counter block supplies
  the sync_stat structure synchronous to pclk.
*/
package sam_pkg;
  typedef enum logic [2:0] {RATE1, RATE2, RATE3, RATE4, RATE5, RATE_OFF} sam_rate_e;
  typedef struct packed {
    logic [11:0] hcount;
    logic hcount_latch;
    logic hpol;
    logic vpol;
    logic hcnt_ov;
    logic vcnt_ov;
  } sam_sync_stat_s;
  typedef struct packed {
    logic [10:0] hdiv;
    logic [10:0] vdiv;
    logic [10:0] hs;
    logic [10:0] hbp;
    logic [10:0] hfp;
    logic [10:0] vs;
    logic [10:0] vbp;
    logic [10:0] vfp;
  } sam_timing_s;
endpackage

// >>> rtl/sam_regs.svh
/*
  register indices, field positions, reset values and timing figures of the
  sync auxiliary block. assumes inclusion by sam_top only.
*/
`ifndef SAM_REGS_SVH
`define SAM_REGS_SVH
`define SAM_IDX_SYNC_OUT 8'h07
`define SAM_IDX_FREERUN 8'h0c
`define SAM_IDX_HALF 8'h0d
`define SAM_IDX_MUTE_CTRL 8'h0e
`define SAM_IDX_MUTE_STAT 8'h16
`define SAM_IDX_MUTE_IE 8'h18
`define SAM_RST_ALL_ONES 8'hff
`define SAM_RST_ZERO 8'h00
`define SAM_B_HALF_EN 7
`define SAM_B_PASS 6
`define SAM_B_HALF_POL 5
`define SAM_B_PAT_EN 7
`define SAM_B_PAT_SEL 6
`define SAM_F_RATE 2:0
`define SAM_B_HOUT 7
`define SAM_B_VOUT 6
`define SAM_B_DIFF 7
`define SAM_B_POLCHK 6
`define SAM_B_OVCHK 5
`define SAM_F_THRESH 3:0
`define SAM_B_MUTE 0
`define SAM_B_FR_ACT 1
`define SAM_CLK_MHZ 50
`define SAM_REF_MHZ 8
`define SAM_NS_PER_US 1000
`define SAM_HPULSE_NS 1000
`define SAM_VPULSE_NS 64000
`define SAM_HDIV1 256
`define SAM_HDIV2 180
`define SAM_HDIV3 128
`define SAM_HDIV4 100
`define SAM_HDIV5 88
`define SAM_VDIV1 512
`define SAM_VDIV2 512
`define SAM_VDIV3 840
`define SAM_VDIV4 1024
`define SAM_VDIV5 1024
`define SAM_VFP1_NS 128000
`define SAM_VFP2_NS 90500
`define SAM_VFP3_NS 51000
`define SAM_VFP4_NS 51500
`define SAM_VFP5_NS 46600
`define SAM_VBP1_NS 864000
`define SAM_VBP2_NS 589000
`define SAM_VBP3_NS 528000
`define SAM_VBP4_NS 596000
`define SAM_VBP5_NS 515000
`define SAM_HFP1_NS 460
`define SAM_HFP2_NS 1180
`define SAM_HFP3_NS 424
`define SAM_HFP4_NS 185
`define SAM_HFP5_NS 436
`define SAM_HBP1_NS 2000
`define SAM_HBP2_NS 1930
`define SAM_HBP3_NS 1920
`define SAM_HBP4_NS 1940
`define SAM_HBP5_NS 1940
`endif

// >>> rtl/sam_top.sv
/*
  half frequency divider, free-run sync generator, self test pattern and sync
  mode change detector with an apb register slave. assumes all inputs are
  synchronous to pclk and the apb master follows the usual protocol.
*/
// The APB register port is this design's own decision.
// Functional notes
// - divider enabled: half output is half input divided by two, 50% duty.
// - pass-through enabled: half output repeats input, polarity bit one is positive.
// - reset: divider, pass-through and polarity bits high, shared pins stay io.
// - rate selection does nothing unless h or v sync output enabled.
// - reset: rate select bits all one, free-run off.
// - codes give h = 8 MHz over 256,180,128,100,88; v over 512,512,840,1024,1024.
// - free-run active and pattern enable cleared: pattern pin becomes push-pull output.
// - pattern enable and select changes ignored while free-run off.
// - pattern select zero gives pattern one, one gives pattern two.
// - pattern uses 64 us v pulse, 1 us h pulse, porches per rate.
// - delta check: new h count differs from previous above threshold sets mute.
// - polarity check: h or v polarity change sets mute flag.
// - overflow check: h or v counter overflow sets mute flag.
// - mute interrupt enabled and mute flag set raises nmi request.
// - reset: all three checks off, threshold all ones.
// - clearing h or v sync output enable turns shared pin into sync output.
`include "sam_regs.svh"
module sam_top
  import sam_pkg::*;
#(
  parameter int HCW = 11,
  parameter int VCW = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic half_input_pin,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire sam_sync_stat_s sync_stat,
  output logic half_output_pin,
  output logic half_output_oe_n,
  output logic horizontal_sync_output,
  output logic horizontal_sync_oe_n,
  output logic vertical_sync_output,
  output logic vertical_sync_oe_n,
  output logic pattern_output_pin,
  output logic pattern_oe_n,
  output logic nmi_req
);
  logic [7:0] half_freq_control_q, freerun_control_q, sync_out_q, mute_ctrl_q;
  logic mute_ie_q, mute_event_flag_q, pat_en_n_q, pat_sel_q;
  logic half_in_q, half_div_q;
  logic [5:0] acc_q;
  logic tick;
  logic [HCW-1:0] h_q;
  logic [VCW-1:0] v_q;
  logic [11:0] hprev_q;
  logic hpol_q, vpol_q;
  logic freerun_act;
  sam_rate_e rate;
  sam_timing_s tm;

  function automatic logic [13:0] byte_addr(input logic [7:0] idx);
    byte_addr = {4'h0, idx, 2'b00};
  endfunction

  function automatic logic [10:0] ns2t(input int ns, input int per);
    int t;
    t = ns * `SAM_REF_MHZ / `SAM_NS_PER_US / per;
    if (t < 1) t = 1;
    ns2t = t[10:0];
  endfunction

  function automatic sam_timing_s timing(input int hd, input int vd, input int vfp,
      input int vbp, input int hfp, input int hbp);
    sam_timing_s r;
    r.hdiv = hd[10:0];
    r.vdiv = vd[10:0];
    r.hs = ns2t(`SAM_HPULSE_NS, 1);
    r.hbp = ns2t(hbp, 1);
    r.hfp = ns2t(hfp, 1);
    r.vs = ns2t(`SAM_VPULSE_NS, hd);
    r.vbp = ns2t(vbp, hd);
    r.vfp = ns2t(vfp, hd);
    timing = r;
  endfunction

  // rate decode, codes 110 and 111 both off
  always_comb begin
    case (freerun_control_q[`SAM_F_RATE])
      3'h0: rate = RATE1;
      3'h1: rate = RATE2;
      3'h2: rate = RATE3;
      3'h3: rate = RATE4;
      3'h4, 3'h5: rate = RATE5;
      default: rate = RATE_OFF;
    endcase
  end

  // per rate divisors and porches
  always_comb begin
    case (rate)
      RATE1: tm = timing(`SAM_HDIV1, `SAM_VDIV1, `SAM_VFP1_NS, `SAM_VBP1_NS,
                         `SAM_HFP1_NS, `SAM_HBP1_NS);
      RATE2: tm = timing(`SAM_HDIV2, `SAM_VDIV2, `SAM_VFP2_NS, `SAM_VBP2_NS,
                         `SAM_HFP2_NS, `SAM_HBP2_NS);
      RATE3: tm = timing(`SAM_HDIV3, `SAM_VDIV3, `SAM_VFP3_NS, `SAM_VBP3_NS,
                         `SAM_HFP3_NS, `SAM_HBP3_NS);
      RATE4: tm = timing(`SAM_HDIV4, `SAM_VDIV4, `SAM_VFP4_NS, `SAM_VBP4_NS,
                         `SAM_HFP4_NS, `SAM_HBP4_NS);
      default: tm = timing(`SAM_HDIV5, `SAM_VDIV5, `SAM_VFP5_NS, `SAM_VBP5_NS,
                           `SAM_HFP5_NS, `SAM_HBP5_NS);
    endcase
  end

  assign freerun_act = (rate != RATE_OFF) &&
      (!sync_out_q[`SAM_B_HOUT] || !sync_out_q[`SAM_B_VOUT]);

  // apb slave, zero wait states
  logic setup, wr;
  logic [13:0] a;
  logic mapped;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign a = {2'b00, paddr};
  assign mapped = (a == byte_addr(`SAM_IDX_SYNC_OUT)) || (a == byte_addr(`SAM_IDX_FREERUN)) ||
      (a == byte_addr(`SAM_IDX_HALF)) || (a == byte_addr(`SAM_IDX_MUTE_CTRL)) ||
      (a == byte_addr(`SAM_IDX_MUTE_STAT)) || (a == byte_addr(`SAM_IDX_MUTE_IE));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce && setup) begin
      prdata <= 32'h0;
      if (a == byte_addr(`SAM_IDX_SYNC_OUT)) prdata[7:0] <= sync_out_q;
      if (a == byte_addr(`SAM_IDX_FREERUN)) prdata[7:0] <= freerun_control_q;
      if (a == byte_addr(`SAM_IDX_HALF)) prdata[7:0] <= half_freq_control_q;
      if (a == byte_addr(`SAM_IDX_MUTE_CTRL)) prdata[7:0] <= mute_ctrl_q;
      if (a == byte_addr(`SAM_IDX_MUTE_STAT)) begin
        prdata[`SAM_B_MUTE] <= mute_event_flag_q;
        prdata[`SAM_B_FR_ACT] <= freerun_act;
      end
      if (a == byte_addr(`SAM_IDX_MUTE_IE)) prdata[0] <= mute_ie_q;
    end
  end

  // control registers, reset to all ones except mute interrupt enable, which resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_freq_control_q <= `SAM_RST_ALL_ONES;
      freerun_control_q <= `SAM_RST_ALL_ONES;
      sync_out_q <= `SAM_RST_ALL_ONES;
      mute_ctrl_q <= `SAM_RST_ALL_ONES;
      mute_ie_q <= 1'b0;
    end else if (ce && wr) begin
      if (a == byte_addr(`SAM_IDX_HALF)) half_freq_control_q <= pwdata[7:0];
      if (a == byte_addr(`SAM_IDX_FREERUN)) freerun_control_q <= pwdata[7:0];
      if (a == byte_addr(`SAM_IDX_SYNC_OUT)) sync_out_q <= pwdata[7:0];
      if (a == byte_addr(`SAM_IDX_MUTE_CTRL)) mute_ctrl_q <= pwdata[7:0];
      if (a == byte_addr(`SAM_IDX_MUTE_IE)) mute_ie_q <= pwdata[0];
    end
  end

  // pattern bits taken from a write only while free-run runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_en_n_q <= 1'b1;
      pat_sel_q <= 1'b1;
    end else if (ce && wr && freerun_act && (a == byte_addr(`SAM_IDX_FREERUN))) begin
      pat_en_n_q <= pwdata[`SAM_B_PAT_EN];
      pat_sel_q <= pwdata[`SAM_B_PAT_SEL];
    end
  end

  // half frequency path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_in_q <= 1'b0;
      half_div_q <= 1'b0;
    end else if (ce) begin
      half_in_q <= half_input_pin;
      if (half_input_pin && !half_in_q) half_div_q <= !half_div_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_output_pin <= 1'b1;
      half_output_oe_n <= 1'b1;
    end else if (ce) begin
      if (!half_freq_control_q[`SAM_B_HALF_EN]) begin
        half_output_pin <= half_div_q;
        half_output_oe_n <= 1'b0;
      end else if (!half_freq_control_q[`SAM_B_PASS]) begin
        half_output_pin <= half_input_pin ~^ half_freq_control_q[`SAM_B_HALF_POL];
        half_output_oe_n <= 1'b0;
      end else begin
        half_output_pin <= 1'b1;
        half_output_oe_n <= 1'b1;
      end
    end
  end

  // 8 MHz reference ticks from pclk by fractional accumulation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 6'h0;
    end else if (ce) begin
      if (acc_q + 6'(`SAM_REF_MHZ) >= 6'(`SAM_CLK_MHZ))
        acc_q <= acc_q + 6'(`SAM_REF_MHZ) - 6'(`SAM_CLK_MHZ);
      else
        acc_q <= acc_q + 6'(`SAM_REF_MHZ);
    end
  end
  assign tick = (acc_q + 6'(`SAM_REF_MHZ)) >= 6'(`SAM_CLK_MHZ);

  // line and frame counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_q <= '0;
      v_q <= '0;
    end else if (ce) begin
      if (!freerun_act) begin
        h_q <= '0;
        v_q <= '0;
      end else if (tick) begin
        if (h_q >= HCW'(tm.hdiv - 11'h1)) begin
          h_q <= '0;
          v_q <= (v_q >= VCW'(tm.vdiv - 11'h1)) ? '0 : v_q + VCW'(1);
        end else begin
          h_q <= h_q + HCW'(1);
        end
      end
    end
  end

  logic hs_gen, vs_gen, vid_act, pat_bit;
  assign hs_gen = h_q < HCW'(tm.hs);
  assign vs_gen = v_q < VCW'(tm.vs);
  assign vid_act = (h_q >= HCW'(tm.hs + tm.hbp)) && (h_q < HCW'(tm.hdiv - tm.hfp)) &&
      (v_q >= VCW'(tm.vs + tm.vbp)) && (v_q < VCW'(tm.vdiv - tm.vfp));
  assign pat_bit = pat_sel_q ? ((h_q[3:0] == 4'h0) || (v_q[3:0] == 4'h0)) : h_q[4];

  // shared sync and pattern pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      horizontal_sync_output <= 1'b1;
      vertical_sync_output <= 1'b1;
      horizontal_sync_oe_n <= 1'b1;
      vertical_sync_oe_n <= 1'b1;
      pattern_output_pin <= 1'b0;
      pattern_oe_n <= 1'b1;
    end else if (ce) begin
      horizontal_sync_oe_n <= sync_out_q[`SAM_B_HOUT];
      vertical_sync_oe_n <= sync_out_q[`SAM_B_VOUT];
      horizontal_sync_output <= freerun_act ? hs_gen : hsync_in;
      vertical_sync_output <= freerun_act ? vs_gen : vsync_in;
      pattern_oe_n <= !(freerun_act && !pat_en_n_q);
      pattern_output_pin <= freerun_act && !pat_en_n_q && vid_act && pat_bit;
    end
  end

  // mode change detection
  logic [11:0] delta;
  logic ev_diff, ev_pol, ev_ov, clr_mute;
  assign delta = (sync_stat.hcount >= hprev_q) ? sync_stat.hcount - hprev_q
                                               : hprev_q - sync_stat.hcount;
  assign ev_diff = !mute_ctrl_q[`SAM_B_DIFF] && sync_stat.hcount_latch &&
      (delta > {8'h0, mute_ctrl_q[`SAM_F_THRESH]});
  assign ev_pol = !mute_ctrl_q[`SAM_B_POLCHK] &&
      ((sync_stat.hpol != hpol_q) || (sync_stat.vpol != vpol_q));
  assign ev_ov = !mute_ctrl_q[`SAM_B_OVCHK] && (sync_stat.hcnt_ov || sync_stat.vcnt_ov);
  assign clr_mute = wr && (a == byte_addr(`SAM_IDX_MUTE_STAT)) && pwdata[`SAM_B_MUTE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hprev_q <= 12'h0;
      hpol_q <= 1'b1;
      vpol_q <= 1'b1;
    end else if (ce) begin
      if (sync_stat.hcount_latch) hprev_q <= sync_stat.hcount;
      hpol_q <= sync_stat.hpol;
      vpol_q <= sync_stat.vpol;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_event_flag_q <= 1'b0;
    end else if (ce) begin
      if (ev_diff || ev_pol || ev_ov) mute_event_flag_q <= 1'b1;
      else if (clr_mute) mute_event_flag_q <= 1'b0;
    end
  end

  assign nmi_req = mute_event_flag_q && mute_ie_q;

  half_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && half_input_pin && !half_in_q |=> half_div_q != $past(half_div_q))
    else $error("divider did not toggle on rising input");
  half_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && half_freq_control_q[`SAM_B_HALF_EN] && !half_freq_control_q[`SAM_B_PASS]
      |=> half_output_pin ==
      ($past(half_input_pin) ~^ $past(half_freq_control_q[`SAM_B_HALF_POL])))
    else $error("pass-through output wrong");
  half_io_a: assert property (@(posedge pclk) disable iff (!presetn)
      half_freq_control_q[`SAM_B_HALF_EN] && half_freq_control_q[`SAM_B_PASS] &&
      $past(half_freq_control_q[`SAM_B_HALF_EN] && half_freq_control_q[`SAM_B_PASS])
      |-> half_output_oe_n)
    else $error("half pin driven while disabled");
  rate_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_out_q[`SAM_B_HOUT] && sync_out_q[`SAM_B_VOUT] |-> !freerun_act)
    else $error("free-run active with sync outputs disabled");
  rate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      freerun_control_q[`SAM_F_RATE] inside {3'h6, 3'h7} |-> rate == RATE_OFF)
    else $error("code 11x not treated as off");
  line_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && tick && freerun_act && h_q == HCW'(tm.hdiv - 11'h1) ##1 freerun_act
      && $stable(rate) |-> h_q == '0)
    else $error("line counter did not wrap at divisor");
  pat_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !freerun_act ##1 !freerun_act |-> $stable(pat_en_n_q) && $stable(pat_sel_q))
    else $error("pattern bits changed while free-run off");
  pat_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && freerun_act && !pat_en_n_q |=> !pattern_oe_n)
    else $error("pattern pin not driven");
  mute_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && (ev_diff || ev_pol || ev_ov) |=> mute_event_flag_q)
    else $error("mute flag not set by event");
  mute_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      mute_event_flag_q && !clr_mute |=> mute_event_flag_q)
    else $error("mute flag dropped without clear");
  nmi_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && (ev_diff || ev_pol || ev_ov) ##1 mute_ie_q |-> nmi_req)
    else $error("nmi request not raised by mute event");
  cov_freerun_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(freerun_act));
  cov_pattern_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(pattern_output_pin));
  cov_nmi_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(nmi_req));
  cov_half_c: cover property (@(posedge pclk) disable iff (!presetn)
      !half_output_oe_n && $rose(half_div_q));
endmodule
